// file: hw/sfcd_pkg.sv
// sfcd_pkg: opcodes, command shapes and timing for the flash command link
package sfcd_pkg;
  // core clock and serial clock timing
  localparam int CLK_NS = 5;
  localparam int SCK_HALF_NS = 80;
  localparam logic [4:0] SCK_HALF_CYC = 5'(SCK_HALF_NS / CLK_NS);
  // frame geometry
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam int ADDR_W = 22;
  localparam logic [8:0] CNT_MAX = 9'h1ff;

  // opcodes
  localparam logic [7:0] OP_RD_FAST2 = 8'h1b;
  localparam logic [7:0] OP_RD_FAST1 = 8'h0b;
  localparam logic [7:0] OP_RD_SLOW = 8'h03;
  localparam logic [7:0] OP_RD_DUAL = 8'h3b;
  localparam logic [7:0] OP_ER_4K = 8'h20;
  localparam logic [7:0] OP_ER_32K = 8'h52;
  localparam logic [7:0] OP_ER_64K = 8'hd8;
  localparam logic [7:0] OP_ER_CHIP_A = 8'h60;
  localparam logic [7:0] OP_ER_CHIP_B = 8'hc7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL = 8'ha2;
  localparam logic [7:0] OP_SUSPEND = 8'hb0;
  localparam logic [7:0] OP_RESUME = 8'hd0;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;
  localparam logic [7:0] OP_RD_PROT = 8'h3c;
  localparam logic [7:0] OP_LOCK = 8'h33;
  localparam logic [7:0] OP_LOCK_FREEZE = 8'h34;
  localparam logic [7:0] OP_RD_LOCK = 8'h35;
  localparam logic [7:0] OP_OTP_PROG = 8'h9b;
  localparam logic [7:0] OP_OTP_RD = 8'h77;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT1 = 8'h01;
  localparam logic [7:0] OP_WR_STAT2 = 8'h31;
  localparam logic [7:0] OP_SW_RESET = 8'hf0;
  localparam logic [7:0] OP_RD_ID = 8'h9f;
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_PWR_UP = 8'hab;

  // data phase: none, many in, exactly one in, stream out
  typedef enum logic [1:0] {DK_NONE, DK_IN, DK_ONE, DK_OUT} sfcd_kind_e;

  typedef struct packed {
    logic valid;
    logic addr;
    logic [1:0] dummy;
    sfcd_kind_e kind;
    logic dual;
  } sfcd_cmd_s;

  // plain numbers in, cut to field width here so no call pads or drops bits
  function automatic sfcd_cmd_s sfcd_cmd(int a, int d,
                                         sfcd_kind_e k, int du);
    sfcd_cmd = '{valid: 1'b1, addr: 1'(a), dummy: 2'(d), kind: k,
                 dual: 1'(du)};
  endfunction

  // shape of each supported command; unknown opcodes come back invalid
  function automatic sfcd_cmd_s sfcd_decode(logic [7:0] op);
    case (op)
      OP_RD_FAST2: sfcd_decode = sfcd_cmd(1, 2, DK_OUT, 0);
      OP_RD_FAST1: sfcd_decode = sfcd_cmd(1, 1, DK_OUT, 0);
      OP_RD_SLOW: sfcd_decode = sfcd_cmd(1, 0, DK_OUT, 0);
      OP_RD_DUAL: sfcd_decode = sfcd_cmd(1, 1, DK_OUT, 1);
      OP_ER_4K, OP_ER_32K, OP_ER_64K:
        sfcd_decode = sfcd_cmd(1, 0, DK_NONE, 0);
      OP_ER_CHIP_A, OP_ER_CHIP_B:
        sfcd_decode = sfcd_cmd(0, 0, DK_NONE, 0);
      OP_PROG: sfcd_decode = sfcd_cmd(1, 0, DK_IN, 0);
      OP_PROG_DUAL: sfcd_decode = sfcd_cmd(1, 0, DK_IN, 1);
      OP_SUSPEND, OP_RESUME:
        sfcd_decode = sfcd_cmd(0, 0, DK_NONE, 0);
      OP_WR_EN, OP_WR_DIS:
        sfcd_decode = sfcd_cmd(0, 0, DK_NONE, 0);
      OP_PROTECT, OP_UNPROTECT:
        sfcd_decode = sfcd_cmd(1, 0, DK_NONE, 0);
      OP_RD_PROT: sfcd_decode = sfcd_cmd(1, 0, DK_OUT, 0);
      OP_LOCK, OP_LOCK_FREEZE:
        sfcd_decode = sfcd_cmd(1, 0, DK_ONE, 0);
      OP_RD_LOCK: sfcd_decode = sfcd_cmd(1, 0, DK_OUT, 0);
      OP_OTP_PROG: sfcd_decode = sfcd_cmd(1, 0, DK_IN, 0);
      OP_OTP_RD: sfcd_decode = sfcd_cmd(1, 2, DK_OUT, 0);
      OP_RD_STAT: sfcd_decode = sfcd_cmd(0, 0, DK_OUT, 0);
      OP_WR_STAT1, OP_WR_STAT2:
        sfcd_decode = sfcd_cmd(0, 0, DK_ONE, 0);
      OP_SW_RESET: sfcd_decode = sfcd_cmd(0, 0, DK_ONE, 0);
      OP_PWR_DOWN, OP_PWR_UP:
        sfcd_decode = sfcd_cmd(0, 0, DK_NONE, 0);
      OP_RD_ID: sfcd_decode = sfcd_cmd(0, 0, DK_OUT, 0);
      default: sfcd_decode = '0;
    endcase
  endfunction
endpackage

// file: hw/sfcd_if.sv
// sfcd_if: serial flash link between host and device, with line resolution
`timescale 1ns/10ps
interface sfcd_if;
  logic csN;
  logic sck;
  logic hostSi;
  logic hostSiOe;
  logic hostSo;
  logic hostSoOe;
  logic devSi;
  logic devSiOe;
  logic devSo;
  logic devSoOe;
  logic siLine;
  logic soLine;

  // undriven lines read high, as with a weak pull-up
  assign siLine = hostSiOe ? hostSi : (devSiOe ? devSi : 1'b1);
  assign soLine = devSoOe ? devSo : (hostSoOe ? hostSo : 1'b1);

  modport host (output csN, sck, hostSi, hostSiOe, hostSo, hostSoOe,
                input siLine, soLine);
  modport dev (input csN, sck, siLine, soLine,
               output devSi, devSiOe, devSo, devSoOe);
endinterface

// file: hw/sfcd_dev.sv
// sfcd_dev: device end, frames and decodes serial flash commands
// Functional notes
// - host opens with chip select, one opcode
// - all bytes travel most significant bit first
// - chip select release ends the operation
// - unknown opcode: ignore input until reselect
// - early release before address: cmdEnd with cmdComplete low, back idle
// - host sends 24-bit address, high byte first
// - top two address bits are dropped
// - reads 1Bh/0Bh/03h: address, 2/1/0 dummies
// - dual read 3Bh: address, one dummy
// - block erases 20h/52h/D8h: address only
// - chip erase on 60h or C7h
// - program 02h: address then data bytes
// - dual program A2h: data on two lines
// - suspend B0h and resume D0h are bare
// - write enable 06h, disable 04h, bare
// - protect/unprotect address only; 3Ch reads back
// - global protect goes through status write
// - lockdown 33h/34h one byte; 35h reads
// - secure register: 9Bh program, 77h read
// - status read 05h; writes 01h/31h one byte
// - reset F0h one byte; B9h/ABh bare
// - identification 9Fh streams bytes until chip select release
// - sample on rising, drive on falling edge
`timescale 1ns/10ps
module sfcd_dev (
  input wire logic core_clk, // 200 MHz core clock
  input wire logic sys_rst, // synchronous reset, active high
  sfcd_if.dev link, // serial link to the host
  output logic cmdStart, // pulse: opcode and address taken
  output logic [7:0] cmdOp, // opcode of current command
  output logic [21:0] cmdAddr, // array address of current command
  output logic rxValid, // pulse: data byte received
  output logic [7:0] rxData, // received data byte
  output logic [8:0] rxCount, // data bytes received, saturating
  output logic txReq, // pulse: txByte taken for output
  input wire logic [7:0] txByte, // next byte to send to the host
  output logic cmdEnd, // pulse: frame closed by chip select
  output logic cmdComplete, // with cmdEnd: opcode and address whole
  output logic cmdReject // pulse: unsupported opcode seen
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_DIN, ST_DOUT, ST_HOLD
  } sfcd_dev_state_e;

  sfcd_dev_state_e state;
  sfcd_pkg::sfcd_cmd_s cur;
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic sckD;
  logic [7:0] rxSh;
  logic [7:0] txSh;
  logic [15:0] addrSh;
  logic [2:0] bitCnt;
  logic [2:0] obit;
  logic [1:0] byteCnt;
  logic hdrDone;
  logic soDrv;
  logic siDrv;
  logic soOe;
  logic siOe;

  // two flops on every pin before any logic looks at it
  wire [3:0] pinIn = {link.csN, link.sck, link.siLine, link.soLine};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        syncA[gi] <= pinIn[gi];
        syncB[gi] <= syncA[gi];
      end
    end
  endgenerate

  // edge detection on the synchronised serial clock
  always_ff @(posedge core_clk) begin
    sckD <= syncB[2];
  end

  wire csAct = !syncB[3];
  wire sckRise = syncB[2] & !sckD;
  wire sckFall = !syncB[2] & sckD;
  wire siS = syncB[1];
  wire soS = syncB[0];

  // input shifting: one bit per clock, two on the dual program data phase
  wire dualIn = (state == ST_DIN) && cur.dual;
  wire [3:0] step = dualIn ? 4'h2 : 4'h1;
  wire [7:0] shIn = dualIn ? {rxSh[5:0], soS, siS} : {rxSh[6:0], siS};
  wire [3:0] bitSum = {1'b0, bitCnt} + step;
  wire byteDone = bitSum[3];
  wire sfcd_pkg::sfcd_cmd_s dec = sfcd_pkg::sfcd_decode(shIn);
  wire [7:0] addrLow = shIn;

  // output shifting: a fresh byte starts whenever the bit count wraps
  wire [7:0] outSrc = (obit == 3'h0) ? txByte : txSh;
  wire [2:0] outStep = cur.dual ? 3'h2 : 3'h1;

  // where a command goes once its header is complete
  function automatic sfcd_dev_state_e after_hdr(sfcd_pkg::sfcd_kind_e k);
    case (k)
      sfcd_pkg::DK_IN, sfcd_pkg::DK_ONE: after_hdr = ST_DIN;
      sfcd_pkg::DK_OUT: after_hdr = ST_DOUT;
      default: after_hdr = ST_HOLD; // bare opcodes ignore any extra bits
    endcase
  endfunction

  // pins come straight from flops
  assign link.devSo = soDrv;
  assign link.devSi = siDrv;
  assign link.devSoOe = soOe;
  assign link.devSiOe = siOe;

  // frame sequencer; chip select release overrides every state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      cur <= '0;
      rxSh <= 8'h00;
      txSh <= 8'h00;
      addrSh <= 16'h0000;
      bitCnt <= 3'h0;
      obit <= 3'h0;
      byteCnt <= 2'h0;
      hdrDone <= 1'b0;
      soDrv <= 1'b0;
      siDrv <= 1'b0;
      soOe <= 1'b0;
      siOe <= 1'b0;
      cmdStart <= 1'b0;
      cmdOp <= 8'h00;
      cmdAddr <= 22'h000000;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxCount <= 9'h000;
      txReq <= 1'b0;
      cmdEnd <= 1'b0;
      cmdComplete <= 1'b0;
      cmdReject <= 1'b0;
    end else begin
      cmdStart <= 1'b0;
      rxValid <= 1'b0;
      txReq <= 1'b0;
      cmdEnd <= 1'b0;
      cmdReject <= 1'b0;
      if (!csAct) begin
        // an unfinished header reports cmdComplete low
        if (state != ST_IDLE) begin
          cmdEnd <= 1'b1;
          cmdComplete <= hdrDone;
        end
        state <= ST_IDLE;
        soOe <= 1'b0;
        siOe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_OP;
            bitCnt <= 3'h0;
            obit <= 3'h0;
            byteCnt <= 2'h0;
            hdrDone <= 1'b0;
            rxCount <= 9'h000;
          end
          ST_HOLD: begin
            // nothing on the link is looked at until reselect
          end
          ST_DOUT: begin
            if (sckFall) begin
              soDrv <= outSrc[7];
              siDrv <= outSrc[6];
              soOe <= 1'b1;
              siOe <= cur.dual;
              txSh <= cur.dual ? {outSrc[5:0], 2'b00} : {outSrc[6:0], 1'b0};
              obit <= obit + outStep;
              txReq <= (obit == 3'h0);
            end
          end
          default: begin
            if (sckRise) begin
              rxSh <= shIn;
              bitCnt <= bitSum[2:0];
            end
            if (sckRise && byteDone) begin
              case (state)
                ST_OP: begin
                  if (!dec.valid) begin
                    state <= ST_HOLD;
                    cmdReject <= 1'b1;
                  end else begin
                    cmdOp <= shIn;
                    cur <= dec;
                    if (dec.addr) begin
                      state <= ST_ADDR;
                    end else begin
                      cmdStart <= 1'b1;
                      hdrDone <= 1'b1;
                      state <= after_hdr(dec.kind);
                    end
                  end
                end
                ST_ADDR: begin
                  addrSh <= {addrSh[7:0], shIn};
                  byteCnt <= byteCnt + 2'h1;
                  if (byteCnt == sfcd_pkg::ADDR_BYTES - 2'h1) begin
                    cmdAddr <= {addrSh[13:0], addrLow};
                    cmdStart <= 1'b1;
                    hdrDone <= 1'b1;
                    byteCnt <= 2'h0;
                    if (cur.dummy != 2'h0) begin
                      state <= ST_DUMMY;
                    end else begin
                      state <= after_hdr(cur.kind);
                    end
                  end
                end
                ST_DUMMY: begin
                  byteCnt <= byteCnt + 2'h1;
                  if (byteCnt + 2'h1 == cur.dummy) begin
                    state <= after_hdr(cur.kind);
                  end
                end
                default: begin
                  // data in; single-byte commands stop listening after one
                  rxData <= shIn;
                  rxValid <= 1'b1;
                  if (rxCount != sfcd_pkg::CNT_MAX) begin
                    rxCount <= rxCount + 9'h001;
                  end
                  if (cur.kind == sfcd_pkg::DK_ONE) begin
                    state <= ST_HOLD;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end
endmodule // sfcd_dev

// file: hw/sfcd_host.sv
// sfcd_host: host end, issues one framed command per request, mode 0
`timescale 1ns/10ps
module sfcd_host (
  input wire logic core_clk, // 200 MHz core clock
  input wire logic sys_rst, // synchronous reset, active high
  sfcd_if.host link, // serial link to the device
  input wire logic reqValid, // start a command when idle
  input wire logic [7:0] reqOp, // opcode to send
  input wire logic [23:0] reqAddr, // address, used if the opcode takes one
  input wire logic [8:0] reqLen, // data bytes to send or read
  input wire logic [7:0] wrByte, // next data byte to send
  output logic wrTaken, // pulse: wrByte taken
  output logic [7:0] rdData, // byte read from the device
  output logic rdValid, // pulse: rdData new
  output logic busy, // frame in progress
  output logic done // pulse: frame finished
);
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_TAIL, H_GAP} sfcd_host_state_e;

  sfcd_host_state_e state;
  sfcd_pkg::sfcd_cmd_s cur;
  logic [1:0] syncA;
  logic [1:0] syncB;
  logic [4:0] div;
  logic [7:0] txSh;
  logic [7:0] rxSh;
  logic [2:0] bitCnt;
  logic [9:0] idx;
  logic [9:0] total;
  logic [2:0] hdr;
  logic [23:0] addr;
  logic csN;
  logic sck;
  logic siDrv;
  logic soDrv;
  logic siOe;
  logic soOe;

  // returning lines pass two flops
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        syncA[gi] <= gi == 0 ? link.soLine : link.siLine;
        syncB[gi] <= syncA[gi];
      end
    end
  endgenerate

  assign link.csN = csN;
  assign link.sck = sck;
  assign link.hostSi = siDrv;
  assign link.hostSo = soDrv;
  assign link.hostSiOe = siOe;
  assign link.hostSoOe = soOe;

  // request shape and byte sequencing
  wire sfcd_pkg::sfcd_cmd_s reqCmd = sfcd_pkg::sfcd_decode(reqOp);
  wire [2:0] reqHdr = 3'h1 + (reqCmd.addr ? 3'h3 : 3'h0) +
                      {1'b0, reqCmd.dummy};
  wire tick = (div == sfcd_pkg::SCK_HALF_CYC - 5'h01);
  wire isWrite = (cur.kind == sfcd_pkg::DK_IN) ||
                 (cur.kind == sfcd_pkg::DK_ONE);
  wire isRead = (cur.kind == sfcd_pkg::DK_OUT);
  wire [9:0] nextIdx = idx + 10'h001;
  wire newByte = (bitCnt == 3'h0);
  wire [9:0] pIdx = newByte ? nextIdx : idx;
  wire pData = (pIdx >= {7'h00, hdr});
  wire curData = (idx >= {7'h00, hdr});
  wire dualNow = cur.dual && pData;
  wire dualCur = cur.dual && curData;
  wire [7:0] loadByte = (cur.addr && nextIdx == 10'h001) ? addr[23:16] :
                        (cur.addr && nextIdx == 10'h002) ? addr[15:8] :
                        (cur.addr && nextIdx == 10'h003) ? addr[7:0] :
                        (pData && isWrite) ? wrByte : 8'h00;
  wire [7:0] src = newByte ? loadByte : txSh;
  wire [3:0] bitSum = {1'b0, bitCnt} + (dualCur ? 4'h2 : 4'h1);
  wire [7:0] rxIn = dualCur ? {rxSh[5:0], syncB[0], syncB[1]} :
                              {rxSh[6:0], syncB[0]};

  // frame engine: clock divider, shifter and chip select
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= H_IDLE;
      cur <= '0;
      div <= 5'h00;
      txSh <= 8'h00;
      rxSh <= 8'h00;
      bitCnt <= 3'h0;
      idx <= 10'h000;
      total <= 10'h000;
      hdr <= 3'h0;
      addr <= 24'h000000;
      csN <= 1'b1;
      sck <= 1'b0;
      siDrv <= 1'b0;
      soDrv <= 1'b0;
      siOe <= 1'b1;
      soOe <= 1'b0;
      wrTaken <= 1'b0;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      wrTaken <= 1'b0;
      rdValid <= 1'b0;
      done <= 1'b0;
      div <= tick ? 5'h00 : div + 5'h01;
      case (state)
        H_IDLE: begin
          div <= 5'h00;
          if (reqValid) begin
            state <= H_RUN;
            busy <= 1'b1;
            cur <= reqCmd;
            hdr <= reqHdr;
            addr <= reqAddr;
            total <= {7'h00, reqHdr} + {1'b0, reqLen};
            csN <= 1'b0;
            siDrv <= reqOp[7];
            siOe <= 1'b1;
            txSh <= {reqOp[6:0], 1'b0};
            bitCnt <= 3'h0;
            idx <= 10'h000;
          end
        end
        H_RUN: begin
          if (tick && !sck) begin
            sck <= 1'b1;
            bitCnt <= bitSum[2:0];
            if (curData && isRead) begin
              rxSh <= rxIn;
              if (bitSum[3]) begin
                rdData <= rxIn;
                rdValid <= 1'b1;
              end
            end
          end else if (tick) begin
            sck <= 1'b0;
            if (newByte && nextIdx == total) begin
              state <= H_TAIL;
            end else begin
              if (newByte) begin
                idx <= nextIdx;
                wrTaken <= pData && isWrite;
              end
              // device takes the two-line pins only in its read data
              siDrv <= dualNow ? src[6] : src[7];
              soDrv <= src[7];
              soOe <= dualNow && isWrite;
              siOe <= !(dualNow && isRead);
              txSh <= dualNow ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
            end
          end
        end
        H_TAIL: begin
          if (tick) begin
            csN <= 1'b1;
            soOe <= 1'b0;
            state <= H_GAP;
          end
        end
        default: begin
          if (tick) begin
            siOe <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule // sfcd_host

// file: tb/sfcd_props.sv
// sfcd_props: link-level assertions for the serial flash command link
`timescale 1ns/10ps
module sfcd_props (
  input wire logic core_clk, // core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic csN, // chip select, active low
  input wire logic sck, // serial clock
  input wire logic siLine, // resolved serial input line
  input wire logic soLine, // resolved serial output line
  input wire logic hostSiOe, // host drives si
  input wire logic hostSoOe, // host drives so
  input wire logic devSiOe, // device drives si
  input wire logic devSoOe // device drives so
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // eight core cycles of one serial clock level
  sequence s_hi8; sck [*8]; endsequence
  sequence s_lo8; !sck [*8]; endsequence
  property p_sck_idle; csN |-> !sck; endproperty
  property p_sck_half; $rose(sck) |-> s_hi8 ##1 s_hi8 ##1 !sck; endproperty
  property p_first_rise; $fell(csN) |-> s_lo8 ##1 !sck [*7]; endproperty
  property p_cs_gap; $rose(csN) |-> csN [*8]; endproperty
  // data may only move while the clock is low
  property p_si_hold;
    !csN && sck && $past(sck) |-> $stable(siLine);
  endproperty
  property p_so_hold;
    !csN && sck && $past(sck) |-> $stable(soLine);
  endproperty
  property p_release;
    csN && $past(csN, 8) |-> !devSoOe && !devSiOe;
  endproperty
  property p_no_clash;
    !(hostSiOe && devSiOe) && !(hostSoOe && devSoOe);
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock not idle low");
  a_sck_half: assert property (p_sck_half)
    else $error("serial clock high phase wrong length");
  a_first_rise: assert property (p_first_rise)
    else $error("serial clock rose too soon after select");
  a_cs_gap: assert property (p_cs_gap)
    else $error("chip select gap too short");
  a_si_hold: assert property (p_si_hold)
    else $error("si changed while clock high");
  a_so_hold: assert property (p_so_hold)
    else $error("so changed while clock high");
  a_release: assert property (p_release)
    else $error("device drives a line while deselected");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive one line");
endmodule // sfcd_props

// file: tb/test_serial_flash_command_decoder.sv
// test_serial_flash_command_decoder: host and device joined over the link
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_serial_flash_command_decoder;
  logic core_clk = 0;
  logic sys_rst = 1;
  int failures = 0;
  int checked = 0;
  logic reqValid = 0;
  logic [7:0] reqOp = 0;
  logic [23:0] reqAddr = 0;
  logic [8:0] reqLen = 0;
  logic [7:0] wrByte = 0;
  logic [7:0] txByte = 0;
  logic [7:0] rdData, cmdOp, rxData, rdExp, rxExp, opSh;
  logic wrTaken, rdValid, busy, done, cmdStart, rxValid, txReq;
  logic cmdEnd, cmdComplete, cmdReject, s2Start, s2End, s2Comp;
  logic eComp, e2Comp, sckQ;
  logic [21:0] cmdAddr;
  logic [8:0] rxCount, eCount;
  int startN, endN, rejN, rdN, rxN, start2N, end2N, bitN;
  logic [15:0] tbl [28] = '{16'h04ff, 16'h131b, 16'h130b, 16'h1303,
    16'h133b, 16'h133c, 16'h1335, 16'h1377, 16'h0305, 16'h039f, 16'h0412,
    16'h1020, 16'h1052, 16'h10d8, 16'h1036, 16'h1039, 16'h0060, 16'h00c7,
    16'h00b0, 16'h00d0, 16'h0006, 16'h0004, 16'h00b9, 16'h00ab, 16'h1102,
    16'h119b, 16'h1233, 16'h1234};
  sfcd_if link();
  sfcd_if link2();

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  sfcd_host i_sfcd_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqLen(reqLen), .wrByte(wrByte), .wrTaken(wrTaken), .rdData(rdData),
    .rdValid(rdValid), .busy(busy), .done(done));
  sfcd_dev i_sfcd_dev (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
    .cmdStart(cmdStart), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .rxValid(rxValid), .rxData(rxData), .rxCount(rxCount), .txReq(txReq),
    .txByte(txByte), .cmdEnd(cmdEnd), .cmdComplete(cmdComplete),
    .cmdReject(cmdReject));
  // second device faces a bench driver of raw frames, some cut short, some whole
  sfcd_dev i_sfcd_dev_2 (.core_clk(core_clk), .sys_rst(sys_rst),
    .link(link2), .cmdStart(s2Start), .cmdOp(), .cmdAddr(), .rxValid(),
    .rxData(), .rxCount(), .txReq(), .txByte(8'h00), .cmdEnd(s2End),
    .cmdComplete(s2Comp), .cmdReject());
  sfcd_props i_sfcd_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .csN(link.csN), .sck(link.sck), .siLine(link.siLine),
    .soLine(link.soLine), .hostSiOe(link.hostSiOe),
    .hostSoOe(link.hostSoOe), .devSiOe(link.devSiOe),
    .devSoOe(link.devSoOe));

  // monitor on the settled half cycle, so no edge races with the flops
  always @(negedge core_clk) begin
    if (link.sck && !sckQ && bitN < 8) begin
      opSh = {opSh[6:0], link.siLine};
      bitN++;
    end
    sckQ = link.sck;
    if (cmdStart) startN++;
    if (cmdReject) rejN++;
    if (cmdEnd) begin
      endN++;
      eComp = cmdComplete;
      eCount = rxCount;
    end
    if (rdValid) begin
      `CHK(rdData, rdExp)
      rdExp++;
      rdN++;
    end
    if (rxValid) begin
      `CHK(rxData, rxExp)
      rxExp++;
      rxN++;
    end
    if (s2Start) start2N++;
    if (s2End) begin
      end2N++;
      e2Comp = s2Comp;
    end
    if (txReq) txByte++;
    if (wrTaken) wrByte++;
  end

  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one framed command; k: 0 bare, 1 data in, 2 one byte, 3 out, 4 unknown
  task automatic t_cmd(input logic [7:0] op, input bit a, input int k,
                       input int n);
    int i;
    int rx;
    @(negedge core_clk);
    {startN, endN, rejN, rdN, rxN, bitN} = '0;
    {txByte, wrByte, rdExp, rxExp} = {4{8'h5a}};
    reqOp = op;
    reqAddr = 24'hfabcde;
    reqLen = 9'(n);
    reqValid = 1;
    @(negedge core_clk);
    reqValid = 0;
    `CHK({busy, link.csN}, 2'b10)
    for (i = 0; i < 40000 && done !== 1'b1; i++) @(negedge core_clk);
    if (i == 40000) begin
      failures++;
      end_sim();
    end
    repeat (4) @(negedge core_clk);
    rx = (k == 1) ? n : (k == 2) ? 1 : 0;
    `CHK(opSh, op)
    `CHK(endN, 1)
    `CHK(busy, 1'b0)
    `CHK(rejN, int'(k == 4))
    `CHK(startN, int'(k != 4))
    `CHK(rxN, rx)
    `CHK(link.csN & ~link.sck, 1'b1)
    if (k != 4) begin
      `CHK(eComp, 1'b1)
      `CHK(cmdOp, op)
      `CHK(eCount, 9'(rx))
      `CHK(rdN, (k == 3) ? n : 0)
    end
    if (a) `CHK(cmdAddr, 22'h3abcde)
  endtask

  // raw frame of nb bits on the second link, then chip select release;
  // m is the idle clock level, so 1 runs the frame in mode 3
  task automatic t_raw(input logic [31:0] v, input int nb, input logic c,
                       input logic m);
    int i;
    @(negedge core_clk);
    {start2N, end2N} = '0;
    link2.sck = m;
    repeat (16) @(negedge core_clk);
    link2.csN = 0;
    link2.hostSiOe = 1;
    for (i = 0; i < nb; i++) begin
      repeat (16) @(negedge core_clk);
      link2.sck = 0;
      link2.hostSi = v[31-i];
      repeat (16) @(negedge core_clk);
      link2.sck = 1;
    end
    repeat (16) @(negedge core_clk);
    link2.sck = m;
    repeat (16) @(negedge core_clk);
    link2.csN = 1;
    link2.hostSiOe = 0;
    repeat (24) @(negedge core_clk);
    `CHK(end2N, 1)
    `CHK(e2Comp, c)
    `CHK(start2N, int'(c))
  endtask

  // main sequence
  initial begin
    {link2.csN, link2.sck, link2.hostSi, link2.hostSiOe} = 4'b1010;
    {link2.hostSo, link2.hostSoOe} = 2'b10;
    repeat (5) @(negedge core_clk);
    sys_rst = 0;
    for (int j = 0; j < 28; j++) begin
      t_cmd(tbl[j][7:0], tbl[j][12], int'(tbl[j][11:8]), 2);
    end
    t_cmd(8'h01, 0, 2, 2);
    t_cmd(8'h31, 0, 2, 2);
    t_cmd(8'hf0, 0, 2, 2);
    t_cmd(8'ha2, 1, 1, 256);
    t_raw(32'h0312_0000, 16, 0, 0);
    t_raw(32'h9800_0000, 5, 0, 0);
    t_raw(32'h0600_0000, 8, 1, 0);
    t_raw(32'h2012_3456, 32, 1, 0);
    t_raw(32'h2012_3456, 32, 1, 1);
    end_sim();
  end
endmodule // test_serial_flash_command_decoder
